// >>> hw/tpsp_dead.sv
`timescale 1ns/1ns
module tpsp_dead
  import tpsp_pkg::*;
#(
  parameter int DEAD = DEAD_CYC
)(
  input  wire logic mclk_i,
  input  wire logic sys_rst_i,
  input  wire logic en_i,
  input  wire logic raw_i,
  output logic      hi_o,
  output logic      lo_o
);

  logic              cur;
  logic [DEAD_W-1:0] cnt;
  logic              next_cur;
  logic [DEAD_W-1:0] next_cnt;
  logic              next_hi;
  logic              next_lo;

  always_comb
  begin
    next_cur = raw_i;
    next_cnt = cnt;
    next_hi  = 1'b0;
    next_lo  = 1'b0;
    if (!en_i)
      next_cnt = DEAD_W'(DEAD);
    // (RULE5) underlap on every edge
    else if (raw_i != cur)
      next_cnt = DEAD_W'(DEAD);
    // last step releases the gate, so the gap is exactly dead cycles
    else if (cnt > DEAD_W'(1))
      next_cnt = cnt - 1'b1;
    else
    begin
      next_cnt = '0;
      next_hi  = cur;
      next_lo  = !cur;
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      cur  <= 1'b0;
      cnt  <= DEAD_W'(DEAD);
      hi_o <= 1'b0;
      lo_o <= 1'b0;
    end
    else
    begin
      cur  <= next_cur;
      cnt  <= next_cnt;
      hi_o <= next_hi;
      lo_o <= next_lo;
    end
  end

endmodule // tpsp_dead

// >>> hw/tpsp_duty_if.sv
`timescale 1ns/1ns
interface tpsp_duty_if;
  import tpsp_pkg::*;
  logic [PTR_W-1:0] ptr;
  logic             dir;
  logic [7:0]       depth;
  logic [7:0]       duty [3];

  modport src (input ptr, input dir, input depth, output duty);
  modport snk (output ptr, output dir, output depth, input duty);
endinterface

// >>> hw/tpsp_pkg.sv
package tpsp_pkg;

  // ----------------------------------------------------------------
  // clock and carrier timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ      = 20_000_000;
  localparam int CLK_MHZ     = CLK_HZ / 1_000_000;
  localparam int CARRIER_HZ  = 20_000;
  localparam int CARRIER_CYC = CLK_HZ / CARRIER_HZ;
  localparam int HALF_CYC    = CARRIER_CYC / 2;
  localparam int TRI_W       = 9;
  localparam logic [TRI_W-1:0] TRI_TOP = TRI_W'(HALF_CYC - 1);
  localparam logic [TRI_W-1:0] TRI_BOT = '0;

  // dead interval, a least time, so rounded up
  localparam int DEAD_NS  = 500;
  localparam int DEAD_CYC = (DEAD_NS * CLK_MHZ + 999) / 1000;
  localparam int DEAD_W   = 5;

  // power-up delay default before the relay closes
  localparam int PWRUP_US_DEF = 100_000;

  // ----------------------------------------------------------------
  // sine table and duty scale
  // ----------------------------------------------------------------
  localparam int PTR_W   = 7;
  localparam int STEPS   = 96;
  localparam int THIRD   = 32;
  localparam int QUARTER = 24;
  localparam logic [7:0] MID       = 8'h80;
  localparam logic [7:0] DUTY_FULL = 8'hff;
  localparam logic [7:0] QSIN [0:24] = '{
    8'h00, 8'h08, 8'h11, 8'h19, 8'h21, 8'h29, 8'h31, 8'h38, 8'h40,
    8'h47, 8'h4d, 8'h54, 8'h5a, 8'h60, 8'h65, 8'h6a, 8'h6e, 8'h72,
    8'h75, 8'h78, 8'h7b, 8'h7d, 8'h7e, 8'h7f, 8'h7f};

  // ----------------------------------------------------------------
  // register map, byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_DEPTH    = 8'h00;
  localparam logic [7:0] ADR_STATUS   = 8'h04;
  localparam logic [7:0] ADR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADR_IRQ_MASK = 8'h0c;
  localparam logic [7:0] ADR_PTR      = 8'h10;
  localparam logic [7:0] DEPTH_RST    = 8'h00;

  // event bits of status and mask
  localparam int EV_RUN  = 0;
  localparam int EV_STOP = 1;
  localparam int EV_DIR  = 2;
  localparam int EV_OVC  = 3;
  localparam int EV_W    = 4;

  // status register bits
  localparam int SB_RUN   = 0;
  localparam int SB_DIR   = 1;
  localparam int SB_RELAY = 2;
  localparam int SB_OVC   = 3;

  // synchronised input index
  localparam int IN_SPD  = 0;
  localparam int IN_RUN  = 1;
  localparam int IN_STOP = 2;
  localparam int IN_DIR  = 3;
  localparam int IN_OVC  = 4;
  localparam int IN_W    = 5;

  typedef enum logic [1:0] {
    S_PWRUP,
    S_IDLE,
    S_RUN,
    S_REV
  } tpsp_state_t;

endpackage

// >>> hw/tpsp_sine.sv
`timescale 1ns/1ns
module tpsp_sine
  import tpsp_pkg::*;
(
  tpsp_duty_if.src d
);

  // ----------------------------------------------------------------
  // table lookup and depth scaling
  // ----------------------------------------------------------------
  function automatic logic [7:0] scaled(input logic [PTR_W-1:0] i,
                                        input logic [7:0] dep);
    logic [7:0]  q;
    logic        neg;
    logic [15:0] p;
    q   = '0;
    neg = 1'b0;
    if (int'(i) < QUARTER)
      q = QSIN[int'(i)];
    else if (int'(i) < 2 * QUARTER)
      q = QSIN[2 * QUARTER - int'(i)];
    else if (int'(i) < 3 * QUARTER)
    begin
      q   = QSIN[int'(i) - 2 * QUARTER];
      neg = 1'b1;
    end
    else
    begin
      q   = QSIN[STEPS - int'(i)];
      neg = 1'b1;
    end
    // deviation from half duty grows with depth
    p = 16'(q) * 16'(dep);
    scaled = neg ? MID - p[15:8] : MID + p[15:8];
  endfunction

  genvar k;
  generate
    for (k = 0; k < 3; k++)
    begin : g_ph
      logic [7:0]       sum;
      logic [PTR_W-1:0] idx;
      always_comb
      begin
        // (RULE12) third-period spacing
        // (RULE9) reverse swaps b and c
        sum = 8'(d.ptr) + 8'(THIRD * (d.dir ? (3 - k) % 3 : k));
        idx = (int'(sum) >= STEPS) ? PTR_W'(int'(sum) - STEPS)
                                   : PTR_W'(sum);
        // (RULE2) depth times table
        d.duty[k] = scaled(idx, d.depth);
      end
    end
  endgenerate

endmodule // tpsp_sine

// >>> hw/tpsp_top.sv
`timescale 1ns/1ns
// Overview of operation
// (RULE1) new duties every 50 us carrier
// (RULE2) depth number scales sine table values
// (RULE3) each oscillator pulse steps the pointer
// (RULE4) three 8-bit duties, lower takes complement
// (RULE5) dead interval keeps pair never both on
// (RULE6) run, stop, direction, overcurrent raise interrupts
// (RULE7) stop or overcurrent turns all gates off
// (RULE8) run request starts gate pulses
// (RULE9) direction change stops, reverses order, resumes
// (RULE10) power-up delay then relay bypass closes
// (RULE11) lower supply enabled at same delay
// (RULE12) three readings spaced one third period
// (RULE13) pulses centred, double-edged modulation
// (RULE14) no oscillator pulses freeze the pointer
// (RULE15) dead parameter, inputs synchronised first
// (RULE16) duties load only at carrier boundary
module tpsp_top
  import tpsp_pkg::*;
#(
  parameter int PWRUP_US = PWRUP_US_DEF
)(
  input  wire logic        mclk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        spd_pulse_i,
  input  wire logic        run_i,
  input  wire logic        stop_i,
  input  wire logic        dir_i,
  input  wire logic        ovc_i,
  output logic      [2:0]  gate_hi_o,
  output logic      [2:0]  gate_lo_o,
  output logic             relay_o,
  output logic             lo_supply_en_o,
  output logic             irq_o
);

  localparam int PWRUP_CYC = PWRUP_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [IN_W-1:0] s1;
  logic [IN_W-1:0] s2;
  logic [IN_W-1:0] s3;
  logic [IN_W-1:0] filt;
  logic [IN_W-1:0] filt_d;
  logic [IN_W-1:0] next_filt;
  logic [IN_W-1:0] rise;

  genvar g;
  generate
    for (g = 0; g < IN_W; g++)
    begin : g_sync
      // (RULE15) accept once two stages agree
      assign next_filt[g] = (s2[g] == s3[g]) ? s3[g] : filt[g];
      assign rise[g]      = filt[g] && !filt_d[g];
    end
  endgenerate

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      s1     <= '0;
      s2     <= '0;
      s3     <= '0;
      filt   <= '0;
      filt_d <= '0;
    end
    else
    begin
      s1     <= {ovc_i, dir_i, stop_i, run_i, spd_pulse_i};
      s2     <= s1;
      s3     <= s2;
      filt   <= next_filt;
      filt_d <= filt;
    end
  end

  logic dir_chg;
  assign dir_chg = filt[IN_DIR] != filt_d[IN_DIR];

  // ----------------------------------------------------------------
  // duty source
  // ----------------------------------------------------------------
  tpsp_duty_if dif ();
  tpsp_sine u_sine (.d(dif.src));

  // ----------------------------------------------------------------
  // control state
  // ----------------------------------------------------------------
  tpsp_state_t      state;
  tpsp_state_t      next_state;
  logic [31:0]      pwr_cnt;
  logic [31:0]      next_pwr_cnt;
  logic             relay;
  logic             next_relay;
  logic [PTR_W-1:0] ptr;
  logic [PTR_W-1:0] next_ptr;
  logic             dir_q;
  logic             next_dir_q;
  logic [TRI_W-1:0] tri_cnt;
  logic [TRI_W-1:0] next_tri_cnt;
  logic             tri_dn;
  logic             next_tri_dn;
  logic             en_q;
  logic             next_en_q;
  logic [7:0]       duty_q [3];
  logic [7:0]       next_duty_q [3];
  logic [7:0]       depth;
  logic             boundary;
  logic             halt;

  assign boundary  = !tri_dn && (tri_cnt == TRI_TOP);
  // level stop or overcurrent keeps the bridge dark
  assign halt      = filt[IN_STOP] || filt[IN_OVC];
  assign dif.ptr   = ptr;
  assign dif.dir   = dir_q;
  assign dif.depth = depth;

  always_comb
  begin
    next_state   = state;
    next_pwr_cnt = pwr_cnt;
    next_relay   = relay;
    next_ptr     = ptr;
    next_dir_q   = dir_q;
    next_tri_cnt = tri_cnt;
    next_tri_dn  = tri_dn;
    next_en_q    = en_q;
    next_duty_q  = duty_q;

    // (RULE13) up-down carrier, pulses centred
    if (!tri_dn)
    begin
      if (tri_cnt == TRI_TOP)
        next_tri_dn = 1'b1;
      else
        next_tri_cnt = tri_cnt + 1'b1;
    end
    else
    begin
      if (tri_cnt == TRI_BOT)
        next_tri_dn = 1'b0;
      else
        next_tri_cnt = tri_cnt - 1'b1;
    end

    // (RULE3) step per oscillator pulse
    // (RULE14) no pulse, pointer holds
    if (rise[IN_SPD])
      next_ptr = (int'(ptr) == STEPS - 1) ? '0 : ptr + 1'b1;

    // (RULE1) fresh duties each carrier
    // (RULE16) swap only at boundary
    if (boundary)
    begin
      next_duty_q = dif.duty;
      next_en_q   = (state == S_RUN) && !halt;
    end

    case (state)
      S_PWRUP:
      begin
        next_dir_q = filt[IN_DIR];
        // (RULE10) relay after power-up delay
        // (RULE11) lower supply on same delay
        if (pwr_cnt >= 32'(PWRUP_CYC - 1))
        begin
          next_relay = 1'b1;
          next_state = S_IDLE;
        end
        else
          next_pwr_cnt = pwr_cnt + 1'b1;
      end
      S_IDLE:
      begin
        next_en_q  = 1'b0;
        next_dir_q = filt[IN_DIR];
        // (RULE8) run request starts pulses
        if (rise[IN_RUN] && !halt)
          next_state = S_RUN;
      end
      S_RUN:
      begin
        // (RULE7) stop or overcurrent, all off
        if (halt)
        begin
          next_en_q  = 1'b0;
          next_state = S_IDLE;
        end
        // (RULE9) stop first on reversal
        else if (dir_chg)
        begin
          next_en_q  = 1'b0;
          next_state = S_REV;
        end
      end
      S_REV:
      begin
        next_en_q = 1'b0;
        if (halt)
          next_state = S_IDLE;
        // dark for at least one whole carrier
        else if (boundary)
        begin
          next_dir_q = filt[IN_DIR];
          next_state = S_RUN;
        end
      end
      default:
      begin
        next_en_q  = 1'b0;
        next_state = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state   <= S_PWRUP;
      pwr_cnt <= '0;
      relay   <= 1'b0;
      ptr     <= '0;
      dir_q   <= 1'b0;
      tri_cnt <= '0;
      tri_dn  <= 1'b0;
      en_q    <= 1'b0;
      duty_q  <= '{default: MID};
    end
    else
    begin
      state   <= next_state;
      pwr_cnt <= next_pwr_cnt;
      relay   <= next_relay;
      ptr     <= next_ptr;
      dir_q   <= next_dir_q;
      tri_cnt <= next_tri_cnt;
      tri_dn  <= next_tri_dn;
      en_q    <= next_en_q;
      duty_q  <= next_duty_q;
    end
  end

  // ----------------------------------------------------------------
  // pulse compare and gate pairs
  // ----------------------------------------------------------------
  function automatic logic pwm_on(input logic [TRI_W-1:0] t,
                                  input logic [7:0] dty);
    logic [16:0] a;
    logic [16:0] b;
    a = 17'(t) * 17'(DUTY_FULL);
    b = 17'(dty) * 17'(HALF_CYC);
    pwm_on = a < b;
  endfunction

  logic gates_en;
  assign gates_en = en_q && !halt && (state == S_RUN);

  generate
    for (g = 0; g < 3; g++)
    begin : g_gate
      logic raw;
      // (RULE4) duty 0 none, ff full
      assign raw = pwm_on(tri_cnt, duty_q[g]);
      tpsp_dead u_dead (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .en_i      (gates_en),
        .raw_i     (raw),
        .hi_o      (gate_hi_o[g]),
        .lo_o      (gate_lo_o[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // wishbone slave and interrupts
  // ----------------------------------------------------------------
  logic [EV_W-1:0] ev;
  logic [EV_W-1:0] stat;
  logic [EV_W-1:0] next_stat;
  logic [EV_W-1:0] mask;
  logic [EV_W-1:0] next_mask;
  logic [7:0]      next_depth;
  logic [31:0]     next_dat;
  logic            next_ack;
  logic            next_irq;
  logic            wr;

  // (RULE6) four input events
  assign ev = {rise[IN_OVC], dir_chg, rise[IN_STOP], rise[IN_RUN]};
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];

  always_comb
  begin
    next_ack   = wb_cyc_i && wb_stb_i && !wb_ack_o;
    next_dat   = wb_dat_o;
    next_depth = depth;
    next_mask  = mask;
    next_stat  = stat;
    if (wr && wb_adr_i == ADR_DEPTH)
      next_depth = wb_dat_i[7:0];
    if (wr && wb_adr_i == ADR_IRQ_MASK)
      next_mask = wb_dat_i[EV_W-1:0];
    if (wr && wb_adr_i == ADR_IRQ_STAT)
      next_stat = stat & ~wb_dat_i[EV_W-1:0];
    // new event wins over a write-one clear
    next_stat = next_stat | ev;
    if (next_ack)
    begin
      next_dat = '0;
      case (wb_adr_i)
        ADR_DEPTH:    next_dat[7:0] = depth;
        ADR_STATUS:
        begin
          next_dat[SB_RUN]   = state == S_RUN;
          next_dat[SB_DIR]   = dir_q;
          next_dat[SB_RELAY] = relay;
          next_dat[SB_OVC]   = filt[IN_OVC];
        end
        ADR_IRQ_STAT: next_dat[EV_W-1:0] = stat;
        ADR_IRQ_MASK: next_dat[EV_W-1:0] = mask;
        ADR_PTR:      next_dat[PTR_W-1:0] = ptr;
        default:      next_dat = '0;
      endcase
    end
    next_irq = |(next_stat & next_mask);
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      wb_ack_o       <= 1'b0;
      wb_dat_o       <= '0;
      depth          <= DEPTH_RST;
      mask           <= '0;
      stat           <= '0;
      irq_o          <= 1'b0;
      relay_o        <= 1'b0;
      lo_supply_en_o <= 1'b0;
    end
    else
    begin
      wb_ack_o       <= next_ack;
      wb_dat_o       <= next_dat;
      depth          <= next_depth;
      mask           <= next_mask;
      stat           <= next_stat;
      irq_o          <= next_irq;
      relay_o        <= next_relay;
      lo_supply_en_o <= next_relay;
    end
  end

endmodule // tpsp_top

// >>> test/three_phase_sine_pwm_test.sv
`timescale 1ns/1ns
module three_phase_sine_pwm_test;
  import tpsp_pkg::*;
  logic        mclk_i = 1'b0;
  logic        sys_rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o;
  logic        spd_pulse_i, run_i, stop_i, dir_i, ovc_i, fault;
  logic        relay_o, lo_supply_en_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [2:0]  gate_hi_o, gate_lo_o;
  int          hi_on [3], lo_on [3], h0 [3], l0 [3];
  int          fail_count = 0, checks = 0, seed = 51232, ptr, dep, n;

  always #25 mclk_i = ~mclk_i;

  tpsp_top #(.PWRUP_US(1)) tpsp_top_inst (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .spd_pulse_i(spd_pulse_i), .run_i(run_i),
    .stop_i(stop_i), .dir_i(dir_i), .ovc_i(ovc_i), .gate_hi_o(gate_hi_o),
    .gate_lo_o(gate_lo_o), .relay_o(relay_o),
    .lo_supply_en_o(lo_supply_en_o), .irq_o(irq_o));
  tpsp_gate_drv tpsp_gate_drv_inst (
    .mclk_i(mclk_i), .hi_i(gate_hi_o), .lo_i(gate_lo_o),
    .supply_en_i(lo_supply_en_o), .fault_i(fault), .ovc_o(ovc_i),
    .hi_on_o(hi_on), .lo_on_o(lo_on));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int c);
    repeat (c) @(posedge mclk_i);
  endtask

  // classic cycle, held until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    int k;
    k = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do
    begin
      @(posedge mclk_i);
      k++;
    end
    while (wb_ack_o !== 1'b1 && k < 50);
    if (k >= 50)
      chk({31'h0, wb_ack_o}, 32'h1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge mclk_i);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0, 4'hf);
    chk(rd, e);
  endtask

  // inputs pass a filter, so pulses stay up for ten cycles
  task automatic pulse(input int w);
    if (w == 0)
      spd_pulse_i <= 1'b1;
    else if (w == 1)
      run_i <= 1'b1;
    else
      stop_i <= 1'b1;
    cyc(10);
    spd_pulse_i <= 1'b0;
    run_i <= 1'b0;
    stop_i <= 1'b0;
    cyc(10);
  endtask

  task automatic ev_check(input int b);
    rd_chk(ADR_IRQ_STAT, 32'(1 << b));
    chk({31'h0, irq_o}, 32'h1);
    wb(1'b1, ADR_IRQ_STAT, 32'(1 << b), 4'h1);
    rd_chk(ADR_IRQ_STAT, 32'h0);
    chk({31'h0, irq_o}, 32'h0);
  endtask

  // ----------------------------------------------------------------
  // reference model: raw on-cycles of one carrier period
  // ----------------------------------------------------------------
  function automatic int raw_on(input int p, input int d);
    int dev, duty, r;
    p = p % STEPS;
    if (p < 24)
      dev = int'(QSIN[p]);
    else if (p < 48)
      dev = int'(QSIN[48 - p]);
    else if (p < 72)
      dev = -int'(QSIN[p - 48]);
    else
      dev = -int'(QSIN[96 - p]);
    duty = dev >= 0 ? 128 + ((dev * d) >> 8) : 128 - (((-dev) * d) >> 8);
    r = 0;
    for (int t = 0; t < HALF_CYC; t++)
      if (t * 255 < duty * 500)
        r += 2;
    return r;
  endfunction

  // window of one carrier after the new duties have settled
  task automatic measure(input bit on);
    int pp, e;
    cyc(2100);
    h0 = hi_on;
    l0 = lo_on;
    cyc(CARRIER_CYC);
    for (int i = 0; i < 3; i++)
    begin
      pp = ptr + THIRD * ((dir_i === 1'b1 && i > 0) ? 3 - i : i);
      e = raw_on(pp, dep);
      chk(32'(hi_on[i] - h0[i]), 32'(on ? e - DEAD_CYC : 0));
      chk(32'(lo_on[i] - l0[i]), 32'(on ? 1000 - e - DEAD_CYC : 0));
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    sys_rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, spd_pulse_i} = 4'h0;
    {run_i, stop_i, dir_i, fault} = 4'h0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    cyc(4);
    sys_rst_i <= 1'b0;
    cyc(1);
    rd_chk(ADR_DEPTH, {24'h0, DEPTH_RST});
    rd_chk(ADR_IRQ_MASK, 32'h0);
    rd_chk(ADR_IRQ_STAT, 32'h0);
    rd_chk(8'h14, 32'h0);
    n = 0;
    while (relay_o !== 1'b1 && n < 200)
    begin
      cyc(1);
      n++;
    end
    chk({31'h0, lo_supply_en_o}, 32'h1);
    rd_chk(ADR_STATUS, 32'h4);
    wb(1'b1, ADR_IRQ_MASK, 32'hf, 4'h1);
    rd_chk(ADR_IRQ_MASK, 32'hf);
    dep = 32 + ($random(seed) & 127);
    wb(1'b1, ADR_DEPTH, 32'(dep), 4'he);
    rd_chk(ADR_DEPTH, 32'h0);
    wb(1'b1, ADR_DEPTH, 32'(dep), 4'h1);
    rd_chk(ADR_DEPTH, 32'(dep));
    ptr = 1 + ($random(seed) & 31);
    repeat (ptr) pulse(0);
    rd_chk(ADR_PTR, 32'(ptr));
    pulse(1);
    ev_check(EV_RUN);
    rd_chk(ADR_STATUS, 32'h5);
    measure(1'b1);
    rd_chk(ADR_PTR, 32'(ptr));
    dir_i <= 1'b1;
    cyc(12);
    ev_check(EV_DIR);
    measure(1'b1);
    rd_chk(ADR_STATUS, 32'h7);
    fault <= 1'b1;
    cyc(12);
    ev_check(EV_OVC);
    measure(1'b0);
    rd_chk(ADR_STATUS, 32'he);
    fault <= 1'b0;
    cyc(12);
    pulse(1);
    ev_check(EV_RUN);
    measure(1'b1);
    pulse(2);
    ev_check(EV_STOP);
    measure(1'b0);
    report_and_stop();
  end

  // hang guard, well past the expected run length
  initial
  begin
    cyc(40000);
    fail_count++;
    report_and_stop();
  end
endmodule // three_phase_sine_pwm_test

// >>> test/tpsp_gate_drv.sv
`timescale 1ns/1ns
module tpsp_gate_drv (
  input  wire logic       mclk_i,
  input  wire logic [2:0] hi_i,
  input  wire logic [2:0] lo_i,
  input  wire logic       supply_en_i,
  input  wire logic       fault_i,
  output logic            ovc_o,
  output int              hi_on_o [3],
  output int              lo_on_o [3]
);
  bit shoot = 1'b0;
  // lower stages conduct only with their floating supply up
  always @(posedge mclk_i)
  begin
    shoot <= |(hi_i & lo_i & {3{supply_en_i}});
    for (int i = 0; i < 3; i++)
    begin
      hi_on_o[i] <= hi_on_o[i] + int'(hi_i[i] === 1'b1);
      lo_on_o[i] <= lo_on_o[i] + int'(lo_i[i] === 1'b1 && supply_en_i);
    end
  end
  // sense line trips on a commanded fault or on shoot-through
  assign ovc_o = fault_i | shoot;
endmodule // tpsp_gate_drv

// >>> test/tpsp_monitor.sv
`timescale 1ns/1ns
module tpsp_monitor
  import tpsp_pkg::*;
#(
  parameter int PWRUP_US = PWRUP_US_DEF
)(
  input wire logic       mclk_i,
  input wire logic       sys_rst_i,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  input wire logic       stop_i,
  input wire logic       ovc_i,
  input wire logic [2:0] gate_hi_o,
  input wire logic [2:0] gate_lo_o,
  input wire logic       relay_o,
  input wire logic       lo_supply_en_o,
  input wire logic       irq_o
);
  localparam int RLY = PWRUP_US * CLK_MHZ;
  logic [31:0] up_cnt;
  logic [10:0] since_rise;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  // ----------------------------------------------------------------
  // helpers: cycles since reset, since last upper pulse on gate_hi_o[0]
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge sys_rst_i)
    if (sys_rst_i)
    begin
      up_cnt     <= '0;
      since_rise <= '1;
    end
    else
    begin
      up_cnt     <= up_cnt + 32'h1;
      since_rise <= $rose(gate_hi_o[0]) ? 11'h0 :
                    (&since_rise ? since_rise : since_rise + 11'h1);
    end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_no_overlap; (gate_hi_o & gate_lo_o) == 3'b000; endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("pair on");
  property p_dead_gap; $fell(gate_hi_o[0]) |-> !gate_lo_o[0] [*8]; endproperty
  a_dead_gap: assert property (p_dead_gap) else $error("no gap");
  property p_stop_off;
    stop_i [*8] |=> gate_hi_o == 3'b000 && gate_lo_o == 3'b000;
  endproperty
  a_stop_off: assert property (p_stop_off) else $error("stop on");
  property p_ovc_off;
    ovc_i [*8] |=> gate_hi_o == 3'b000 && gate_lo_o == 3'b000;
  endproperty
  a_ovc_off: assert property (p_ovc_off) else $error("ovc on");
  property p_supply_pair; relay_o == lo_supply_en_o; endproperty
  a_supply_pair: assert property (p_supply_pair) else $error("skew");
  property p_quiet_early;
    !relay_o |-> gate_hi_o == 3'b000 && gate_lo_o == 3'b000;
  endproperty
  a_quiet_early: assert property (p_quiet_early)
    else $error("early");
  property p_relay_early; relay_o |-> up_cnt >= RLY - 2; endproperty
  a_relay_early: assert property (p_relay_early) else $error("soon");
  property p_relay_late; up_cnt == RLY + 4 |-> relay_o; endproperty
  a_relay_late: assert property (p_relay_late) else $error("late");
  property p_carrier; $rose(gate_hi_o[0]) |-> since_rise >= 400; endproperty
  a_carrier: assert property (p_carrier) else $error("period");
  property p_ack_once; $rose(wb_ack_o) |=> !wb_ack_o; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack long");
  property p_ack_next;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("no ack");
  c_relay: cover property ($rose(relay_o));
  c_pulse: cover property ($rose(gate_hi_o[2]));
  c_irq: cover property ($rose(irq_o));
endmodule // tpsp_monitor

bind tpsp_top tpsp_monitor #(.PWRUP_US(PWRUP_US)) tpsp_monitor_inst (
  .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .stop_i(stop_i),
  .ovc_i(ovc_i), .gate_hi_o(gate_hi_o), .gate_lo_o(gate_lo_o),
  .relay_o(relay_o), .lo_supply_en_o(lo_supply_en_o), .irq_o(irq_o));
